// ===== src/exposure_seq_pkg.sv
package exposure_seq_pkg;

	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] off_ctrl      = 8'h00;
	localparam logic [7:0] off_images    = 8'h04;
	localparam logic [7:0] off_exptime   = 8'h08;
	localparam logic [7:0] off_period    = 8'h0c;
	localparam logic [7:0] off_delay     = 8'h10;
	localparam logic [7:0] off_expframe  = 8'h14;
	localparam logic [7:0] off_status    = 8'h18;
	localparam logic [7:0] off_imgnum    = 8'h1c;

	// Control register fields.
	localparam int ctrl_mode_lsb = 0;
	localparam int ctrl_arm_bit  = 2;
	localparam int ctrl_stop_bit = 3;

	// Values after reset.
	localparam logic [31:0] images_rst   = 32'h0000_0001;
	localparam logic [31:0] exptime_rst  = 32'h0000_0001;
	localparam logic [31:0] period_rst   = 32'h0004_93e4;
	localparam logic [31:0] delay_rst    = 32'h0000_0000;
	localparam logic [31:0] expframe_rst = 32'h0000_0001;

	// Least readout time in ns and its cycle count at 100 MHz.
	localparam longint readout_min_ns = 3000000;
	localparam longint clk_period_ns  = 10;
	localparam logic [31:0] readout_min_cyc =
		32'((readout_min_ns + clk_period_ns - 1) / clk_period_ns);

	typedef enum logic [1:0] {
		mode_single,
		mode_multi,
		mode_enable
	} acq_mode_t;

	typedef enum logic [2:0] {
		st_idle,
		st_armed,
		st_delay,
		st_expose,
		st_gap,
		st_readout,
		st_period
	} seq_state_t;

	// Exposure and readout strobes towards the pixel counters.
	typedef struct packed {
		logic        counting;
		logic        readout;
		logic        frame_done;
		logic [31:0] image_number;
	} counter_ctrl_t;

endpackage

// ===== src/external_exposure_sequencer.sv
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module external_exposure_sequencer
	import exposure_seq_pkg::*;
#(
	parameter int cnt_w = 32
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        trigger_in,
	output counter_ctrl_t    ctr,
	output logic             counter_gate
);

	// Software settings.
	logic [1:0]       mode_r;
	logic [cnt_w-1:0] images_r;
	logic [cnt_w-1:0] exptime_r;
	logic [cnt_w-1:0] period_r;
	logic [cnt_w-1:0] delay_r;
	logic [cnt_w-1:0] expframe_r;
	logic             arm_r;
	logic             stop_r;

	// Settings captured at arm so mid-series writes do not disturb timing.
	logic [1:0]       amode_r;
	logic [cnt_w-1:0] aimages_r;
	logic [cnt_w-1:0] aexp_r;
	logic [cnt_w-1:0] aper_r;
	logic [cnt_w-1:0] adelay_r;
	logic [cnt_w-1:0] aframe_r;

	seq_state_t       state_r;
	logic [cnt_w-1:0] timer_r;
	logic [cnt_w-1:0] ptimer_r;
	logic [cnt_w-1:0] img_cnt_r;
	logic [cnt_w-1:0] exp_cnt_r;
	logic [31:0]      img_num_r;
	logic             trig_s1_r;
	logic             trig_s2_r;
	logic             trig_d_r;
	logic             trig_rise;
	logic             trig_fall;

	// AHB-Lite address phase capture.
	logic             dp_wr_r;
	logic             dp_rd_r;
	logic [7:0]       dp_addr_r;
	logic             take;

	// A transfer is taken only when the slot is selected, the bus is ready
	// and the master drives a NONSEQ or SEQ code. BUSY and IDLE codes fall
	// through without side effects, so a master that parks on this slave
	// cannot write a register by accident.
	// The slave never stretches a transfer: every register is a plain flop,
	// so there is nothing to wait for and hreadyout stays high throughout.
	assign take = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Address phase is held for exactly one data phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r   <= 1'b0;
			dp_rd_r   <= 1'b0;
			dp_addr_r <= 8'h00;
		end else begin
			dp_wr_r   <= take & hwrite;
			dp_rd_r   <= take & ~hwrite;
			dp_addr_r <= haddr[7:0];
		end
	end

	// Register writes land at the end of the data phase, when hwdata stands.
	// Arm and stop last one cycle only, so a second write of the same value
	// is needed to re-arm; software never has to clear them itself.
	// Mode is kept apart from arm so that a new mode can be chosen without
	// starting a series, and arm then picks it up.
	// Register writes; arm and stop are self-clearing pulses.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r     <= 2'h0;
			images_r   <= cnt_w'(images_rst);
			exptime_r  <= cnt_w'(exptime_rst);
			period_r   <= cnt_w'(period_rst);
			delay_r    <= cnt_w'(delay_rst);
			expframe_r <= cnt_w'(expframe_rst);
			arm_r      <= 1'b0;
			stop_r     <= 1'b0;
		end else begin
			arm_r  <= 1'b0;
			stop_r <= 1'b0;
			if (dp_wr_r) begin
				if (dp_addr_r == off_ctrl) begin
					mode_r <= hwdata[ctrl_mode_lsb +: 2];
					arm_r  <= hwdata[ctrl_arm_bit];
					stop_r <= hwdata[ctrl_stop_bit];
				end else if (dp_addr_r == off_images) begin
					images_r <= cnt_w'(hwdata);
				end else if (dp_addr_r == off_exptime) begin
					exptime_r <= cnt_w'(hwdata);
				end else if (dp_addr_r == off_period) begin
					period_r <= cnt_w'(hwdata);
				end else if (dp_addr_r == off_delay) begin
					delay_r <= cnt_w'(hwdata);
				end else if (dp_addr_r == off_expframe) begin
					expframe_r <= cnt_w'(hwdata);
				end
			end
		end
	end

	// The read word is formed in the address phase and registered, so it is
	// steady through the whole data phase. Status and image number are live
	// values; a read racing a state change returns the value of the cycle
	// in which the address was taken.
	// Read mux; unmapped addresses read as zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take & ~hwrite) begin
			if (haddr[7:0] == off_ctrl) begin
				hrdata <= {30'h0, mode_r};
			end else if (haddr[7:0] == off_images) begin
				hrdata <= 32'(images_r);
			end else if (haddr[7:0] == off_exptime) begin
				hrdata <= 32'(exptime_r);
			end else if (haddr[7:0] == off_period) begin
				hrdata <= 32'(period_r);
			end else if (haddr[7:0] == off_delay) begin
				hrdata <= 32'(delay_r);
			end else if (haddr[7:0] == off_expframe) begin
				hrdata <= 32'(expframe_r);
			end else if (haddr[7:0] == off_status) begin
				hrdata <= {29'h0, state_r};
			end else if (haddr[7:0] == off_imgnum) begin
				hrdata <= img_num_r;
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// The trigger pin is asynchronous to hclk. Reading it straight into the
	// state logic could let two branches see different values in one cycle,
	// so timed modes use only the synchronised copy. This costs two to
	// three cycles of latency and one cycle of jitter on the exposure start.
	// Trigger pin passes three flops; edges are taken from the second and third.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_d_r  <= 1'b0;
		end else begin
			trig_s1_r <= trigger_in;
			trig_s2_r <= trig_s1_r;
			trig_d_r  <= trig_s2_r;
		end
	end

	assign trig_rise = trig_s2_r & ~trig_d_r;
	assign trig_fall = ~trig_s2_r & trig_d_r;

	// Zero and one are both treated as a single unit.
	function automatic logic [cnt_w-1:0] at_least_one(
		input logic [cnt_w-1:0] v
	);
		at_least_one = (v == '0) ? cnt_w'(1) : v;
	endfunction

	// Readout time is period minus exposure, never below the minimum.
	function automatic logic [cnt_w-1:0] readout_len(
		input logic [cnt_w-1:0] per,
		input logic [cnt_w-1:0] exp
	);
		logic [cnt_w-1:0] r;
		r = (per > exp) ? per - exp : '0;
		readout_len = (r < cnt_w'(readout_min_cyc)) ?
			cnt_w'(readout_min_cyc) : r;
	endfunction

	// Stop wins over arm, and both win over the running sequence, so a
	// software abort always takes effect on the next edge.
	// The exposure timer counts down to zero and holds there; the period
	// timer runs alongside it so the next single-mode cycle starts on the
	// period boundary whatever the readout took.
	// Settings are latched at arm, so writes during a series wait for the
	// next arm before they change anything.
	// Sequencer: one process for state, timers and image numbering.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r   <= st_idle;
			amode_r   <= 2'h0;
			aimages_r <= '0;
			aexp_r    <= '0;
			aper_r    <= '0;
			adelay_r  <= '0;
			aframe_r  <= '0;
			timer_r   <= '0;
			ptimer_r  <= '0;
			img_cnt_r <= '0;
			exp_cnt_r <= '0;
			img_num_r <= 32'h0000_0000;
		end else if (stop_r) begin
			state_r <= st_idle;
		end else if (arm_r) begin
			// Latch settings as cycle counts and restart numbering.
			amode_r   <= mode_r;
			aimages_r <= at_least_one(images_r);
			aexp_r    <= at_least_one(exptime_r);
			aper_r    <= period_r;
			adelay_r  <= delay_r;
			aframe_r  <= at_least_one(expframe_r);
			img_cnt_r <= '0;
			exp_cnt_r <= '0;
			img_num_r <= 32'h0000_0001;
			state_r   <= st_armed;
		end else begin
			if (timer_r != '0) begin
				timer_r <= timer_r - cnt_w'(1);
			end
			if (ptimer_r != '0) begin
				ptimer_r <= ptimer_r - cnt_w'(1);
			end
			case (state_r)
				st_idle: begin
				end
				st_armed: begin
					// Enable mode ignores delay, exposure time and period.
					if (amode_r == mode_enable) begin
						if (trig_rise) begin
							state_r <= st_expose;
						end
					end else if (trig_rise) begin
						if (adelay_r == '0) begin
							state_r  <= st_expose;
							timer_r  <= aexp_r - cnt_w'(1);
							ptimer_r <= aexp_r + readout_len(aper_r, aexp_r)
								- cnt_w'(1);
						end else begin
							state_r <= st_delay;
							timer_r <= adelay_r - cnt_w'(1);
						end
					end
				end
				st_delay: begin
					if (timer_r == '0) begin
						state_r  <= st_expose;
						timer_r  <= aexp_r - cnt_w'(1);
						ptimer_r <= aexp_r + readout_len(aper_r, aexp_r)
							- cnt_w'(1);
					end
				end
				st_expose: begin
					// Enable mode ends on the gate; others on the timer.
					if ((amode_r == mode_enable) ? trig_fall
						: (timer_r == '0)) begin
						if (exp_cnt_r + cnt_w'(1) < aframe_r) begin
							// Bundled exposure: no readout in between.
							exp_cnt_r <= exp_cnt_r + cnt_w'(1);
							state_r   <= st_gap;
						end else begin
							exp_cnt_r <= '0;
							state_r   <= st_readout;
							timer_r   <= cnt_w'(readout_min_cyc) - cnt_w'(1);
						end
					end
				end
				st_gap: begin
					// Next exposure, of the same frame or, after a readout, of the next one.
					if (amode_r == mode_enable) begin
						if (trig_rise) begin
							state_r <= st_expose;
						end
					end else if (amode_r == mode_multi) begin
						if (trig_rise) begin
							state_r <= st_expose;
							timer_r <= aexp_r - cnt_w'(1);
						end
					end else begin
						state_r <= st_expose;
						timer_r <= aexp_r - cnt_w'(1);
					end
				end
				st_readout: begin
					// At least the readout minimum after each frame.
					if (timer_r == '0) begin
						if (img_cnt_r + cnt_w'(1) >= aimages_r) begin
							img_cnt_r <= '0;
							// Multi and enable rearm; single is done.
							state_r <= (amode_r == mode_single) ?
								st_idle : st_armed;
							if (amode_r != mode_single) begin
								img_num_r <= img_num_r + 32'h0000_0001;
							end
						end else begin
							img_cnt_r <= img_cnt_r + cnt_w'(1);
							img_num_r <= img_num_r + 32'h0000_0001;
							if (amode_r == mode_single) begin
								state_r <= st_period;
							end else if (amode_r == mode_multi) begin
								state_r <= st_gap;
							end else begin
								state_r <= st_gap;
							end
						end
					end
				end
				st_period: begin
					// Later trigger edges are not looked at here.
					if (ptimer_r == '0) begin
						state_r  <= st_expose;
						timer_r  <= aexp_r - cnt_w'(1);
						ptimer_r <= aexp_r + readout_len(aper_r, aexp_r)
							- cnt_w'(1);
					end
				end
				default: begin
					state_r <= st_idle;
				end
			endcase
		end
	end

	// This path is deliberately unsynchronised: in enable mode the pixel
	// counters must follow the gate with no clock delay. The state terms
	// only choose the source, and they change on hclk, so the gate itself
	// carries the asynchronous pin edge to the counters.
	// In enable mode the raw pin gates the counters with no clock delay while armed, exposing or in the gap; in readout the gate is low.
	assign counter_gate = (amode_r == mode_enable && (state_r == st_expose
		|| state_r == st_gap || state_r == st_armed)) ?
		trigger_in : (state_r == st_expose);

	// The strobes lag the state by one cycle; all of them share that lag,
	// so their relative timing towards the pixel array is exact.
	// Counter strobes towards the pixel array.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctr <= '0;
		end else begin
			ctr.counting     <= (state_r == st_expose);
			ctr.readout      <= (state_r == st_readout);
			ctr.frame_done   <= (state_r == st_readout) && (timer_r == '0);
			ctr.image_number <= img_num_r;
		end
	end

endmodule

// ===== bench/exposure_seq_props.sv
`timescale 1ns/1ps
// Port checks; one clock domain, so clock and reset are given once.
module exposure_seq_props
	import exposure_seq_pkg::*;
#(
	parameter int cnt_w = 32
) (
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire logic          hsel,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic          hready,
	input wire logic [31:0]   hrdata,
	input wire logic          hreadyout,
	input wire logic          hresp,
	input wire counter_ctrl_t ctr,
	input wire logic          counter_gate
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [31:0] rd_cnt_r;
	logic        rd_req;
	// Readout length is counted here; a repetition would be far too long.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rd_cnt_r <= 32'h0;
		else if (ctr.readout)
			rd_cnt_r <= rd_cnt_r + 32'h1;
		else if (ctr.counting)
			rd_cnt_r <= 32'h0;
	end
	assign rd_req = hsel && hready && htrans[1] && !hwrite;
	property p_ready; hreadyout == 1'b1; endproperty
	a_ready: assert property (p_ready) else $error("wait state");
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_excl; !(ctr.counting && ctr.readout); endproperty
	a_excl: assert property (p_excl) else $error("overlap");
	property p_done; ctr.frame_done |=> !ctr.frame_done; endproperty
	a_done: assert property (p_done) else $error("long done");
	property p_src; ctr.frame_done |-> ctr.readout || $past(ctr.readout);
	endproperty
	a_src: assert property (p_src) else $error("stray done");
	property p_rdlen; ctr.frame_done |-> rd_cnt_r >= readout_min_cyc - 1;
	endproperty
	a_rdlen: assert property (p_rdlen) else $error("short rd");
	property p_num; ctr.counting |-> ctr.image_number != 32'h0; endproperty
	a_num: assert property (p_num) else $error("number 0");
	property p_step; $changed(ctr.image_number) |->
		ctr.image_number == $past(ctr.image_number) + 32'h1 ||
		ctr.image_number == 32'h1 || ctr.image_number == 32'h0;
	endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_hold; !$past(rd_req) |-> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("hrdata moved");
	c_exp: cover property ($rose(ctr.counting));
	c_rd: cover property ($rose(ctr.readout));
	c_gate: cover property ($rose(counter_gate));
endmodule
bind external_exposure_sequencer exposure_seq_props #(.cnt_w(cnt_w)) i_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .ctr(ctr),
	.counter_gate(counter_gate));

// ===== bench/trigger_source.sv
`timescale 1ns/1ps
// Pulse generator: the pin idles low and stays high width cycles per fire.
module trigger_source (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       fire,
	input wire logic [7:0] width,
	output logic           trig
);
	logic [7:0] left_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			left_r <= 8'h0;
		else if (fire)
			left_r <= width;
		else if (left_r != 8'h0)
			left_r <= left_r - 8'h1;
	end
	assign trig = (left_r != 8'h0);
endmodule

// ===== bench/external_exposure_sequencer_tb_top.sv
`timescale 1ns/1ps
module external_exposure_sequencer_tb_top
	import exposure_seq_pkg::*;
;
	logic          hclk = 1'b0;
	logic          hresetn = 1'b0;
	logic          hsel = 1'b0;
	logic          hwrite = 1'b0;
	logic          fire = 1'b0;
	logic [1:0]    htrans = 2'b00;
	logic [31:0]   haddr = 32'h0;
	logic [31:0]   hwdata = 32'h0;
	logic [7:0]    width = 8'h0;
	logic [31:0]   hrdata, rd;
	logic          hreadyout, hresp, counter_gate, trigger_in;
	counter_ctrl_t ctr;
	int            err_total = 0, n_tests = 0, cyc = 0, n0, n4, w;
	always #5 hclk = ~hclk;
	external_exposure_sequencer i_external_exposure_sequencer (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .trigger_in(trigger_in), .ctr(ctr),
		.counter_gate(counter_gate));
	trigger_source i_trigger_source (.hclk(hclk), .hresetn(hresetn),
		.fire(fire), .width(width), .trig(trigger_in));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One single AHB-Lite transfer; read data is taken at the data edge.
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task pulse(input logic [7:0] wd);
		@(posedge hclk);
		fire <= 1'b1;
		width <= wd;
		@(posedge hclk);
		fire <= 1'b0;
	endtask
	// Cycles until counting starts, then how long it stays high.
	// The strobe is looked at 1 ns after the edge, once it has settled.
	task expo(output int n, output int m);
		n = 0;
		m = 0;
		while (ctr.counting !== 1'b1) begin
			@(posedge hclk);
			#1;
			n++;
		end
		while (ctr.counting === 1'b1) begin
			@(posedge hclk);
			#1;
			m++;
		end
	endtask
	task single(output int n);
		bus(1'b1, off_ctrl, 32'h4);
		rchk("armed", off_status, 32'h1);
		pulse(8'h4);
		expo(n, w);
		chk("expose", 32'ha, 32'(w));
		chk("number", 32'h1, ctr.image_number);
		repeat (2) @(posedge hclk);
		chk("readout", 32'h1, 32'(ctr.readout));
		pulse(8'h4);
		repeat (8) @(posedge hclk);
		rchk("ignored", off_status, 32'h5);
		bus(1'b1, off_ctrl, 32'h8);
		rchk("stopped", off_status, 32'h0);
	endtask
	task final_report;
		if (err_total == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// A hang is cut short well beyond the few hundred cycles needed.
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report;
		end
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("images", off_images, images_rst);
		rchk("period", off_period, period_rst);
		rchk("delay", off_delay, delay_rst);
		rchk("expframe", off_expframe, expframe_rst);
		rchk("unmapped", 8'h20, 32'h0);
		bus(1'b1, off_status, 32'h5);
		rchk("status ro", off_status, 32'h0);
		bus(1'b1, off_exptime, 32'ha);
		bus(1'b1, off_images, 32'h2);
		rchk("images wr", off_images, 32'h2);
		single(n0);
		bus(1'b1, off_delay, 32'h4);
		single(n4);
		chk("delay", 32'(n0 + 4), 32'(n4));
		chk("latency", 32'h1, 32'(n0 <= 19));
		// Multi trigger, two exposures per frame, one pulse each.
		bus(1'b1, off_expframe, 32'h2);
		bus(1'b1, off_ctrl, 32'h5);
		pulse(8'h4);
		expo(n0, w);
		chk("multi exp", 32'ha, 32'(w));
		repeat (4) @(posedge hclk);
		chk("no gap", 32'h0, 32'(ctr.readout));
		pulse(8'h4);
		expo(n0, w);
		chk("multi exp2", 32'ha, 32'(w));
		repeat (2) @(posedge hclk);
		chk("frame rd", 32'h1, 32'(ctr.readout));
		bus(1'b1, off_ctrl, 32'h8);
		// Enable mode ignores the delay and exposure time still loaded.
		bus(1'b1, off_ctrl, 32'h6);
		pulse(8'h7);
		@(posedge hclk);
		chk("gate", 32'h1, 32'(counter_gate));
		repeat (12) @(posedge hclk);
		chk("en gap", 32'h0, 32'(ctr.readout));
		pulse(8'h7);
		repeat (12) @(posedge hclk);
		chk("en frame", 32'h1, 32'(ctr.readout));
		final_report;
	end
endmodule
